// ===== grp_top.sv
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
`include "grp_consts.svh"
module grp_top #(
	parameter int TICK_CYC = `GRP_TICK_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire grp_pkg::grp_rx_t rx,
	output grp_pkg::grp_adc_req_t adc_req,
	input wire grp_pkg::grp_adc_rsp_t adc_rsp,
	input wire logic [1:0] addr_jmp,
	input wire logic [3:0] io_in,
	output logic [3:0] io_out,
	output logic [3:0] io_oe,
	output logic status_led
);
	import grp_pkg::*;

	// =================================================================
	// Declarations
	logic [3:0] dir_r, dir_nxt; // 1 = input
	logic [3:0] type_r, type_nxt; // 1 = analogue
	logic [3:0] out_r, out_nxt; // Output levels
	logic [3:0] in_r, in_nxt; // Sampled digital inputs
	logic [3:0] in_s1_r, in_s2_r; // Pin synchroniser
	logic [1:0] jmp_s1_r, jmp_s2_r; // Jumper synchroniser
	logic [7:0] addr_r, addr_nxt; // Last bus address byte
	logic [5:0] ptr_r, ptr_nxt; // Data port pointer
	logic [31:0] prdata_r, prdata_nxt;
	logic [7:0] shadow_r [`GRP_GPS_BYTES]; // Frame being received
	logic [7:0] live_r [`GRP_GPS_BYTES]; // Registers seen by software
	logic [7:0] adc_r [4]; // Conversion results
	logic [5:0] widx_r, widx_nxt; // Shadow fill index
	logic fix_r, fix_nxt, mov_r, mov_nxt;
	logic pfix_r, pfix_nxt, pmov_r, pmov_nxt; // Status of shadow frame
	logic [20:0] tick_cnt_r, tick_cnt_nxt;
	logic [3:0] sec_cnt_r, sec_cnt_nxt;
	logic [2:0] led_cnt_r, led_cnt_nxt;
	logic led_r, led_nxt;
	logic tick, sec_tick, full, copy;
	grp_adc_st_t st_r, st_nxt;
	logic [1:0] chan_r, chan_nxt;
	logic [3:0] ana;
	logic setup, acc_wr, acc_rd, mapped, match, rd_mode, sel_data;

	// =================================================================
	// APB decode
	// Zero wait states; an unmapped offset answers with an error
	assign setup = psel && !penable;
	assign acc_wr = psel && penable && pwrite;
	assign acc_rd = psel && penable && !pwrite;
	assign sel_data = (paddr == `GRP_OFS_DATA);
	assign mapped = (paddr == `GRP_OFS_DIR) || (paddr == `GRP_OFS_TYPE) ||
		(paddr == `GRP_OFS_OUT) || (paddr == `GRP_OFS_IN) ||
		(paddr[7:4] == 4'h1) || (paddr == `GRP_OFS_STAT) ||
		(paddr == `GRP_OFS_ADDR) || (paddr == `GRP_OFS_PTR) || sel_data;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign prdata = prdata_r;
	// Data port opens only for our own address byte
	assign match = (addr_r[7:1] == {`GRP_DEV_ID, jmp_s2_r});
	assign rd_mode = addr_r[0];

	// =================================================================
	// Register file next state
	// Read data is captured in the setup cycle so it sits in a flop
	always_comb begin
		dir_nxt = dir_r;
		type_nxt = type_r;
		out_nxt = out_r;
		addr_nxt = addr_r;
		ptr_nxt = ptr_r;
		prdata_nxt = prdata_r;
		if (acc_wr) begin
			unique case (paddr)
				`GRP_OFS_DIR: dir_nxt = pwdata[3:0];
				`GRP_OFS_TYPE: type_nxt = pwdata[3:0];
				`GRP_OFS_OUT: out_nxt = pwdata[3:0];
				`GRP_OFS_ADDR: addr_nxt = pwdata[7:0];
				`GRP_OFS_PTR: ptr_nxt = pwdata[5:0];
				`GRP_OFS_DATA: begin
					// Write mode reaches the three setup registers
					if (match && !rd_mode) begin
						if (ptr_r == 6'h00) dir_nxt = pwdata[3:0];
						if (ptr_r == 6'h01) type_nxt = pwdata[3:0];
						if (ptr_r == 6'h02) out_nxt = pwdata[3:0];
						if (ptr_r < `GRP_NWR) ptr_nxt = ptr_r + 6'h01;
					end
				end
				default: begin
					// Read-only or unmapped: ignored
				end
			endcase
		end
		// Read mode pointer steps after each byte returned
		if (acc_rd && sel_data && match && rd_mode) begin
			ptr_nxt = ptr_r + 6'h01;
		end
		if (setup) begin
			prdata_nxt = 32'h0000_0000;
			unique case (paddr)
				`GRP_OFS_DIR: prdata_nxt[3:0] = dir_r;
				`GRP_OFS_TYPE: prdata_nxt[3:0] = type_r;
				`GRP_OFS_OUT: prdata_nxt[3:0] = out_r;
				`GRP_OFS_IN: prdata_nxt[3:0] = in_r;
				`GRP_OFS_STAT: prdata_nxt[4:0] =
					{led_r, mov_r, fix_r, match, rd_mode};
				`GRP_OFS_ADDR: prdata_nxt[7:0] = addr_r;
				`GRP_OFS_PTR: prdata_nxt[5:0] = ptr_r;
				`GRP_OFS_DATA: begin
					if (match && rd_mode &&
						ptr_r < 6'(`GRP_GPS_BYTES)) begin
						prdata_nxt[7:0] = live_r[ptr_r];
					end
				end
				default: begin
					if (paddr[7:4] == 4'h1) begin
						prdata_nxt[7:0] = adc_r[paddr[3:2]];
					end
				end
			endcase
		end
	end

	// Register file flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dir_r <= `GRP_DIR_RST;
			type_r <= `GRP_TYPE_RST;
			out_r <= `GRP_OUT_RST;
			addr_r <= `GRP_ADDR_RST;
			ptr_r <= 6'h00;
			prdata_r <= 32'h0000_0000;
		end else begin
			dir_r <= dir_nxt;
			type_r <= type_nxt;
			out_r <= out_nxt;
			addr_r <= addr_nxt;
			ptr_r <= ptr_nxt;
			prdata_r <= prdata_nxt;
		end
	end

	// =================================================================
	// Pin port: synchronisers and digital input capture
	// Analogue and output lines read back as zero
	always_comb begin
		in_nxt = in_s2_r & dir_r & ~type_r;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			in_s1_r <= 4'h0;
			in_s2_r <= 4'h0;
			jmp_s1_r <= 2'h0;
			jmp_s2_r <= 2'h0;
			in_r <= 4'h0;
		end else begin
			in_s1_r <= io_in;
			in_s2_r <= in_s1_r;
			jmp_s1_r <= addr_jmp;
			jmp_s2_r <= jmp_s1_r;
			in_r <= in_nxt;
		end
	end

	// A zero direction bit drives the pin
	assign io_oe = ~dir_r;
	assign io_out = out_r;

	// =================================================================
	// Time base: 100 ms enable and one-second enable
	assign tick = (tick_cnt_r == 21'(TICK_CYC - 1));
	assign sec_tick = tick && (sec_cnt_r == `GRP_SEC_TICKS);

	always_comb begin
		tick_cnt_nxt = tick ? 21'h00_0000 : tick_cnt_r + 21'h00_0001;
		sec_cnt_nxt = sec_cnt_r;
		if (tick) begin
			sec_cnt_nxt = sec_tick ? 4'h0 : sec_cnt_r + 4'h1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt_r <= 21'h00_0000;
			sec_cnt_r <= 4'h0;
		end else begin
			tick_cnt_r <= tick_cnt_nxt;
			sec_cnt_r <= sec_cnt_nxt;
		end
	end

	// =================================================================
	// Position data: shadow fill and once-a-second publish
	// Only a complete frame is published, all bytes in one edge, so the
	// live registers never mix two refreshes
	assign full = (widx_r == 6'(`GRP_GPS_BYTES));
	assign copy = sec_tick && full;

	always_comb begin
		widx_nxt = widx_r;
		pfix_nxt = pfix_r;
		pmov_nxt = pmov_r;
		fix_nxt = fix_r;
		mov_nxt = mov_r;
		if (copy) begin
			fix_nxt = pfix_r;
			mov_nxt = pmov_r;
			widx_nxt = 6'h00;
		end
		// A start of frame restarts the fill
		if (rx.sof) begin
			widx_nxt = 6'h00;
		end else if (rx.vld && !full && !copy) begin
			widx_nxt = widx_r + 6'h01;
			pfix_nxt = rx.fix;
			pmov_nxt = rx.moving;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			widx_r <= 6'h00;
			pfix_r <= 1'b0;
			pmov_r <= 1'b0;
			fix_r <= 1'b0;
			mov_r <= 1'b0;
		end else begin
			widx_r <= widx_nxt;
			pfix_r <= pfix_nxt;
			pmov_r <= pmov_nxt;
			fix_r <= fix_nxt;
			mov_r <= mov_nxt;
		end
	end

	// One byte lane per register
	for (genvar g = 0; g < `GRP_GPS_BYTES; g++) begin : g_gps
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				shadow_r[g] <= 8'h00;
				live_r[g] <= 8'h00;
			end else begin
				if (rx.vld && !rx.sof && !full && !copy &&
					widx_r == 6'(g)) begin
					shadow_r[g] <= rx.dat;
				end
				if (copy) begin
					live_r[g] <= shadow_r[g];
				end
			end
		end
	end

	// =================================================================
	// Status light
	// No fix forces steady on at once; flashing steps on the 100 ms tick
	always_comb begin
		led_nxt = led_r;
		led_cnt_nxt = led_cnt_r;
		if (!fix_r) begin
			led_nxt = 1'b1;
			led_cnt_nxt = 3'h0;
		end else if (tick && mov_r) begin
			led_nxt = !led_r;
			led_cnt_nxt = 3'h0;
		end else if (tick) begin
			led_cnt_nxt = led_cnt_r + 3'h1;
			if (led_cnt_r == `GRP_SLOW_TICKS) begin
				led_nxt = !led_r;
				led_cnt_nxt = 3'h0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			led_r <= 1'b1;
			led_cnt_r <= 3'h0;
		end else begin
			led_r <= led_nxt;
			led_cnt_r <= led_cnt_nxt;
		end
	end
	assign status_led = led_r;

	// =================================================================
	// Converter sequencer: walks the lines once per 100 ms tick
	// A tick during a sweep is skipped rather than queued
	assign ana = dir_r & type_r;
	assign adc_req.start = (st_r == GRP_ADC_REQ) && ana[chan_r];
	assign adc_req.chan = chan_r;

	always_comb begin
		st_nxt = st_r;
		chan_nxt = chan_r;
		unique case (st_r)
			GRP_ADC_IDLE: begin
				if (tick) begin
					st_nxt = GRP_ADC_REQ;
					chan_nxt = 2'h0;
				end
			end
			GRP_ADC_REQ: begin
				if (ana[chan_r]) begin
					st_nxt = GRP_ADC_WAIT;
				end else begin
					chan_nxt = chan_r + 2'h1;
					if (chan_r == 2'h3) st_nxt = GRP_ADC_IDLE;
				end
			end
			GRP_ADC_WAIT: begin
				if (adc_rsp.done) begin
					chan_nxt = chan_r + 2'h1;
					st_nxt = (chan_r == 2'h3) ? GRP_ADC_IDLE : GRP_ADC_REQ;
				end
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= GRP_ADC_IDLE;
			chan_r <= 2'h0;
			for (int i = 0; i < 4; i++) adc_r[i] <= 8'h00;
		end else begin
			st_r <= st_nxt;
			chan_r <= chan_nxt;
			if (st_r == GRP_ADC_WAIT && adc_rsp.done) begin
				adc_r[chan_r] <= adc_rsp.data;
			end
		end
	end

	// =================================================================
	// Checks
	sequence s_sweep_start;
		tick && st_r == GRP_ADC_IDLE && ana[0];
	endsequence
	sequence s_req_out;
		adc_req.start && adc_req.chan == 2'h0;
	endsequence
	chk_adc_sweep: assert property (@(posedge pclk) disable iff (!presetn)
		s_sweep_start |-> ##1 s_req_out)
		else $error("sweep did not request line 0");
	chk_adc_store: assert property (@(posedge pclk) disable iff (!presetn)
		st_r == GRP_ADC_WAIT && adc_rsp.done |=>
		adc_r[$past(chan_r)] == $past(adc_rsp.data))
		else $error("conversion result not stored");
	chk_led_steady: assert property (@(posedge pclk) disable iff (!presetn)
		!fix_r |=> status_led)
		else $error("light not steady without fix");
	chk_led_fast: assert property (@(posedge pclk) disable iff (!presetn)
		tick && fix_r && mov_r && $past(fix_r) |=>
		status_led != $past(status_led))
		else $error("light did not toggle while moving");
	chk_gps_copy: assert property (@(posedge pclk) disable iff (!presetn)
		copy |=> live_r[0] == $past(shadow_r[0]) &&
		live_r[39] == $past(shadow_r[39]))
		else $error("frame not published whole");
	chk_din_path: assert property (@(posedge pclk) disable iff (!presetn)
		$past(dir_r) == dir_r && $past(type_r) == type_r |->
		in_r == ($past(io_in, 3) & $past(dir_r) & ~$past(type_r)))
		else $error("input register does not follow pin");
	chk_out_write: assert property (@(posedge pclk) disable iff (!presetn)
		acc_wr && paddr == `GRP_OFS_OUT |=>
		io_out == $past(pwdata[3:0]))
		else $error("output pins ignore write");
	chk_dir_oe: assert property (@(posedge pclk) disable iff (!presetn)
		acc_wr && paddr == `GRP_OFS_DIR |=>
		io_oe == ~$past(pwdata[3:0]))
		else $error("enable does not follow direction");
	chk_ptr_step: assert property (@(posedge pclk) disable iff (!presetn)
		acc_rd && sel_data && match && rd_mode |=>
		ptr_r == $past(ptr_r) + 6'h01)
		else $error("pointer did not advance");
	chk_addr_gate: assert property (@(posedge pclk) disable iff (!presetn)
		psel && penable && sel_data && !match |=> $stable(ptr_r))
		else $error("foreign address moved pointer");
	chk_rw_mode: assert property (@(posedge pclk) disable iff (!presetn)
		acc_wr && sel_data && rd_mode |=>
		$stable(dir_r) && $stable(type_r) && $stable(out_r))
		else $error("write taken in read mode");
endmodule : grp_top

// ===== grp_consts.svh
// Operation
// - GPS registers refresh once every second
// - Status light: steady, slow or fast flash
// - Four IO lines, each individually configurable
// - Digital input level stored in readable register
// - Digital output follows output register bit
// - Analogue lines converted every 100 ms automatically
// - Analogue results are eight bits wide
// - Bus address is 11010 plus two jumpers
// - Address LSB one reads, zero writes
// - Direction bit one input, zero output
// - Pointer auto-increments after each byte read
`ifndef GRP_CONSTS_SVH
`define GRP_CONSTS_SVH
// =====================================================================
// Register offsets (byte addresses)
`define GRP_OFS_DIR 8'h00
`define GRP_OFS_TYPE 8'h04
`define GRP_OFS_OUT 8'h08
`define GRP_OFS_IN 8'h0C
`define GRP_OFS_ADC0 8'h10
`define GRP_OFS_STAT 8'h20
`define GRP_OFS_ADDR 8'h24
`define GRP_OFS_PTR 8'h28
`define GRP_OFS_DATA 8'h2C
// =====================================================================
// Fields and reset values
`define GRP_DEV_ID 5'h1A
`define GRP_DIR_RST 4'hF
`define GRP_TYPE_RST 4'h0
`define GRP_OUT_RST 4'h0
`define GRP_ADDR_RST 8'h00
`define GRP_GPS_BYTES 40
`define GRP_NWR 6'h03
// =====================================================================
// Timing
`define GRP_CLK_HZ 20000000
`define GRP_TICK_MS 100
`define GRP_TICK_CYC (`GRP_CLK_HZ / 1000 * `GRP_TICK_MS)
`define GRP_SEC_TICKS 4'h9
`define GRP_SLOW_TICKS 3'h4
`endif

// ===== grp_pkg.sv
package grp_pkg;
	// Byte stream from the position receiver, same clock domain
	typedef struct packed {
		logic sof;
		logic vld;
		logic [7:0] dat;
		logic fix;
		logic moving;
	} grp_rx_t;
	// Conversion request to the 8-bit converter
	typedef struct packed {
		logic start;
		logic [1:0] chan;
	} grp_adc_req_t;
	// Conversion answer
	typedef struct packed {
		logic done;
		logic [7:0] data;
	} grp_adc_rsp_t;
	// Converter sequencer states
	typedef enum logic [1:0] {
		GRP_ADC_IDLE = 2'b00,
		GRP_ADC_REQ = 2'b01,
		GRP_ADC_WAIT = 2'b10
	} grp_adc_st_t;
endpackage : grp_pkg

// ===== grp_adc_model.sv
`timescale 1ns/10ps
// ==============================================
// Converter model: answers each start request
module grp_adc_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire grp_pkg::grp_adc_req_t adc_req,
	input wire logic [31:0] lvl,
	output grp_pkg::grp_adc_rsp_t adc_rsp
);
	import grp_pkg::*;
	logic busy_r; // Conversion in flight
	logic [2:0] wait_r; // Cycles left before done
	logic [1:0] chan_r; // Channel held from the request
	// Random delay covers prompt and slow answers;
	// data is inverted while idle so stale values never match
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_r <= 1'b0;
			wait_r <= 3'h0;
			chan_r <= 2'h0;
			adc_rsp <= '0;
		end else begin
			adc_rsp.done <= 1'b0;
			if (adc_req.start && !busy_r) begin
				busy_r <= 1'b1;
				chan_r <= adc_req.chan;
				wait_r <= 3'($urandom_range(6, 0));
			end else if (busy_r && wait_r != 3'h0) begin
				wait_r <= wait_r - 3'h1;
			end else if (busy_r) begin
				busy_r <= 1'b0;
				adc_rsp.done <= 1'b1;
				adc_rsp.data <= lvl[8*chan_r +: 8];
			end else begin
				adc_rsp.data <= ~adc_rsp.data;
			end
		end
	end
endmodule : grp_adc_model

// ===== testbench.sv
`timescale 1ns/10ps
`include "grp_consts.svh"
// ==============================================
// Register bus bench for the position and IO block
module testbench;
	import grp_pkg::*;
	localparam int TICK = 40; // Short tick keeps the run brief
	localparam logic [7:0] MISS = 8'h30; // Nothing mapped here
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic status_led, last_err;
	logic [7:0] paddr, old_b;
	logic [31:0] pwdata, prdata, lvl;
	logic [3:0] io_in, io_out, io_oe, r;
	logic [1:0] addr_jmp;
	grp_rx_t rx;
	grp_adc_req_t adc_req;
	grp_adc_rsp_t adc_rsp;
	logic [31:0] exp_q[$]; // Read data still owed
	logic [7:0] frm[40]; // Frame being sent
	int error_cnt, check_count, cyc;
	// ==============================================
	// Design and converter model
	grp_top #(.TICK_CYC(TICK)) grp_top_i(.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rx(rx), .adc_req(adc_req),
		.adc_rsp(adc_rsp), .addr_jmp(addr_jmp), .io_in(io_in),
		.io_out(io_out), .io_oe(io_oe), .status_led(status_led));
	grp_adc_model grp_adc_model_i(.pclk(pclk), .presetn(presetn),
		.adc_req(adc_req), .lvl(lvl), .adc_rsp(adc_rsp));
	// ==============================================
	// Clock, hang guard and read monitor
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	// A hang counts as a mismatch
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 15000) begin
			error_cnt++;
			close_out();
		end
	end
	// Oldest owed value meets each completed read
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			chk("prdata", exp_q.pop_front(), prdata);
		end
	end
	// ==============================================
	// Tasks
	task automatic chk(input string nm, input logic [31:0] e, g);
		check_count++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	// One APB transfer, then an idle cycle
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask : rd
	// New random frame from the receiver; data line inverted when idle
	task automatic send(input logic fx, mv);
		for (int k = 0; k < 40; k++) frm[k] = 8'($urandom);
		rx <= '{1'b1, 1'b0, 8'h5A, fx, mv};
		@(posedge pclk);
		for (int k = 0; k < 40; k++) begin
			rx <= '{1'b0, 1'b1, frm[k], fx, mv};
			@(posedge pclk);
		end
		rx <= '{1'b0, 1'b0, ~frm[39], fx, mv};
		repeat (11 * TICK + 10) @(posedge pclk);
	endtask : send
	// Burst through the pointer, then one read past the end
	task automatic rd_all();
		wr(`GRP_OFS_PTR, 32'h0);
		for (int k = 0; k < 40; k++) begin
			rd(`GRP_OFS_DATA, {24'h0, frm[k]});
		end
		rd(`GRP_OFS_DATA, 32'h0);
	endtask : rd_all
	// Counts indicator changes over n cycles
	task automatic led_cnt(input int n, input int e);
		int t;
		logic p;
		t = 0;
		p = status_led;
		repeat (n) begin
			@(posedge pclk);
			if (status_led !== p) t++;
			p = status_led;
		end
		chk("led toggles", 32'(e), 32'(t));
	endtask : led_cnt
	task automatic close_out();
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : close_out
	// ==============================================
	// Main sequence
	initial begin
		void'($urandom(32'h6028C146));
		{psel, penable, pwrite, presetn} = 4'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		rx = '0;
		addr_jmp = 2'($urandom);
		io_in = 4'h0;
		lvl = $urandom;
		repeat (4) @(posedge pclk);
		chk("io_oe", 32'h0, {28'h0, io_oe});
		chk("io_out", 32'h0, {28'h0, io_out});
		chk("led", 32'h1, {31'h0, status_led});
		@(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(`GRP_OFS_DIR, 32'hF);
		rd(`GRP_OFS_TYPE, 32'h0);
		io_in <= 4'($urandom);
		repeat (4) @(posedge pclk);
		wr(`GRP_OFS_IN, 32'h0);
		rd(`GRP_OFS_IN, {28'h0, io_in});
		rd(MISS, 32'h0);
		chk("pslverr", 32'h1, {31'h0, last_err});
		r = 4'($urandom);
		wr(`GRP_OFS_DIR, 32'h5);
		wr(`GRP_OFS_OUT, {28'h0, r});
		chk("io_oe", 32'hA, {28'h0, io_oe});
		chk("io_out", {28'h0, r}, {28'h0, io_out});
		// Status shows address match and transfer direction
		wr(`GRP_OFS_ADDR, {24'h0, `GRP_DEV_ID, addr_jmp, 1'b1});
		rd(`GRP_OFS_STAT, 32'h13);
		// Read mode refuses a write through the data port
		wr(`GRP_OFS_DATA, 32'h0);
		rd(`GRP_OFS_DIR, 32'h5);
		wr(`GRP_OFS_ADDR, {24'h0, `GRP_DEV_ID, ~addr_jmp, 1'b1});
		rd(`GRP_OFS_STAT, 32'h11);
		// Foreign address byte: data port reads zero, pointer stays put
		rd(`GRP_OFS_DATA, 32'h0);
		rd(`GRP_OFS_PTR, 32'h0);
		wr(`GRP_OFS_ADDR, {24'h0, `GRP_DEV_ID, addr_jmp, 1'b0});
		rd(`GRP_OFS_STAT, 32'h12);
		// Write mode: pointer walks DIR, TYPE, OUT; a fourth is dropped
		r = 4'($urandom);
		wr(`GRP_OFS_PTR, 32'h0);
		wr(`GRP_OFS_DATA, 32'hF);
		wr(`GRP_OFS_DATA, 32'h3);
		wr(`GRP_OFS_DATA, {28'h0, r});
		wr(`GRP_OFS_DATA, 32'h0);
		rd(`GRP_OFS_PTR, 32'h3);
		rd(`GRP_OFS_TYPE, 32'h3);
		rd(`GRP_OFS_OUT, {28'h0, r});
		// Analogue lines 0 and 1 read back as zero in the input register
		rd(`GRP_OFS_IN, {28'h0, io_in & 4'hC});
		chk("io_oe", 32'h0, {28'h0, io_oe});
		// Two sweeps with fresh levels, no request from the bus
		for (int p = 0; p < 2; p++) begin
			repeat (3 * TICK) @(posedge pclk);
			for (int k = 0; k < 2; k++) begin
				rd(`GRP_OFS_ADC0 + 8'(4 * k), {24'h0, lvl[8*k +: 8]});
			end
			// Line 2 is a digital input, so it is never converted
			rd(`GRP_OFS_ADC0 + 8'h08, 32'h0);
			lvl <= $urandom;
		end
		send(1'b1, 1'b1);
		wr(`GRP_OFS_ADDR, {24'h0, `GRP_DEV_ID, addr_jmp, 1'b1});
		rd_all();
		led_cnt(10 * TICK, 10);
		// Old set must stay readable while the next frame arrives
		old_b = frm[0];
		fork
			send(1'b1, 1'b0);
			begin
				wr(`GRP_OFS_PTR, 32'h0);
				rd(`GRP_OFS_DATA, {24'h0, old_b});
			end
		join
		rd_all();
		led_cnt(50 * TICK, 10);
		send(1'b0, 1'b0);
		led_cnt(4 * TICK, 0);
		close_out();
	end
endmodule : testbench
